// >>> rtl/ctxb_cfg.svh
`ifndef CTXB_CFG_SVH
`define CTXB_CFG_SVH
// register byte offsets
`define CTXB_ADDR_ADD_REQ 8'h00
`define CTXB_ADDR_CANCEL_REQ 8'h04
`define CTXB_ADDR_PENDING 8'h08
`define CTXB_ADDR_CANCEL_FIN 8'h0c
`define CTXB_ADDR_OCCURRED 8'h10
`define CTXB_ADDR_CORE_CTRL 8'h14
`define CTXB_ADDR_BUF_FMT 8'h18 // per buffer: frame is fd above eight bytes
`define CTXB_ADDR_PAYLOAD 8'h20
// core control fields
`define CTXB_CTRL_DAR_BIT 0
`define CTXB_CTRL_RST 32'h00000000
// sizes
`define CTXB_NBUF 4
`define CTXB_FIFO_DEPTH 4
// fd frames above this byte count carry the false-cancel window
`define CTXB_FD_CLASSIC_MAX 7'd8
`endif

// >>> rtl/ctxb_pkg.sv
package ctxb_pkg;
	typedef logic [3:0] ctxb_mask_t;
	typedef logic [1:0] ctxb_idx_t;
	typedef enum logic [1:0]
	{
		CTXB_IDLE = 2'b00,
		CTXB_SEND = 2'b01
	} ctxb_state_e;
endpackage : ctxb_pkg

// >>> rtl/ctxb_pick.sv
`timescale 1ns/10ps
`include "ctxb_cfg.svh"
// ---------------------------------------------------------------
// lowest set bit picker
// ---------------------------------------------------------------
module ctxb_pick
(
	// request vector
	input wire logic [3:0] req_i,
	// result
	output logic any_o,
	output logic [1:0] idx_o
);
	// scan from the top so the lowest index wins
	always_comb
	begin
		any_o = |req_i;
		idx_o = 2'h0;
		for (int i = `CTXB_NBUF - 1; i >= 0; i--)
		begin
			if (req_i[i])
			begin
				idx_o = 2'(i);
			end
		end
	end
endmodule : ctxb_pick

// >>> rtl/ctxb_top.sv
`timescale 1ns/10ps
`include "ctxb_cfg.svh"
// Operation
// - pending dedicated buffers are sent lowest index first
// - queue buffers give no order guarantee; fifo used for order
// - fifo entries are sent in the order they were queued
// - finished cancel sets cancel-finished and clears pending
// - successful send sets the occurred bit; unsent leaves it zero
// - with retransmit enabled a failed buffer is sent again
// - cleared pending bit reports buffer free to rewrite
// - started frame runs to end; early retry cancel misreports
// - misreport only for fd frames longer than eight bytes
module ctxb_top
(
	// clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// software fifo push
	input wire logic fifo_push_i,
	input wire logic [31:0] fifo_data_i,
	input wire logic [6:0] fifo_len_i,
	input wire logic fifo_fd_i,
	output logic fifo_full_o,
	// protocol controller side
	output logic tx_valid_o,
	output logic [31:0] tx_data_o,
	output logic tx_from_fifo_o,
	output logic [1:0] tx_idx_o,
	input wire logic tx_start_i,
	input wire logic tx_id_phase_i,
	input wire logic tx_done_i,
	input wire logic tx_ok_i
);
	typedef struct packed
	{
		logic [31:0] rd;
		logic ack;
		logic [3:0] pend;
		logic [3:0] cfin;
		logic [3:0] occ;
		logic [3:0] retry;
		logic disable_auto_retransmit;
		logic [3:0][31:0] pay;
		logic [3:0][6:0] len;
		logic [3:0] fd;
		logic [3:0] lfd;
		logic [3:0][31:0] fq;
		logic [1:0] wp;
		logic [1:0] rp;
		logic [2:0] cnt;
		ctxb_pkg::ctxb_state_e st;
		logic busy_fifo;
		logic [1:0] bidx;
		logic [31:0] txd;
		logic vld;
	} ctxb_s;

	ctxb_s q_r, q_nxt;
	logic pick_any;
	logic [1:0] pick_idx;
	logic wr, rd;
	logic [3:0] cancel_now;

	assign wr = cyc_i && stb_i && we_i && !q_r.ack;
	assign rd = cyc_i && stb_i && !we_i && !q_r.ack;

	// cancel bits raised by this cycle's bus write
	assign cancel_now = (wr && adr_i == `CTXB_ADDR_CANCEL_REQ && sel_i[0])
		? dat_i[3:0] : 4'h0;

	// a buffer cancelled in this cycle is never picked, so no frame
	// goes out behind a cancel report made in the idle state
	ctxb_pick u_pick
	(
		.req_i(q_r.pend & ~cancel_now),
		.any_o(pick_any),
		.idx_o(pick_idx)
	);

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb
	begin
		logic [31:0] m;
		logic [3:0] cr;
		m = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
		cr = cancel_now;
		q_nxt = q_r;
		q_nxt.ack = cyc_i && stb_i && !q_r.ack;
		q_nxt.rd = 32'h0;
		// register reads, unmapped reads as zero
		if (rd)
		begin
			unique case (adr_i)
				`CTXB_ADDR_PENDING: q_nxt.rd = {28'h0, q_r.pend};
				`CTXB_ADDR_CANCEL_FIN: q_nxt.rd = {28'h0, q_r.cfin};
				`CTXB_ADDR_OCCURRED: q_nxt.rd = {28'h0, q_r.occ};
				`CTXB_ADDR_CORE_CTRL: q_nxt.rd = {31'h0, q_r.disable_auto_retransmit};
				`CTXB_ADDR_BUF_FMT: q_nxt.rd = {28'h0, q_r.lfd};
				default: q_nxt.rd = 32'h0;
			endcase
		end
		// register writes
		if (wr)
		begin
			if (adr_i == `CTXB_ADDR_CORE_CTRL && sel_i[0])
			begin
				q_nxt.disable_auto_retransmit = dat_i[`CTXB_CTRL_DAR_BIT];
			end
			if (adr_i == `CTXB_ADDR_BUF_FMT && sel_i[0])
			begin
				q_nxt.lfd = dat_i[3:0];
			end
			if (adr_i == `CTXB_ADDR_ADD_REQ && sel_i[0])
			begin
				// one write may raise several, taken together
				q_nxt.pend = q_r.pend | dat_i[3:0];
				q_nxt.cfin = q_r.cfin & ~dat_i[3:0];
				q_nxt.occ = q_r.occ & ~dat_i[3:0];
			end
			for (int i = 0; i < `CTXB_NBUF; i++)
			begin
				// rewrites only touch the buffer store, not txd
				if (adr_i == 8'(`CTXB_ADDR_PAYLOAD + 4 * i))
				begin
					q_nxt.pay[i] = (q_r.pay[i] & ~m) | (dat_i & m);
				end
			end
		end
		// fifo push, refused when full
		if (fifo_push_i && q_r.cnt != 3'd4)
		begin
			q_nxt.fq[q_r.wp] = fifo_data_i;
			q_nxt.len[q_r.wp] = fifo_len_i;
			q_nxt.fd[q_r.wp] = fifo_fd_i;
			q_nxt.wp = q_r.wp + 2'h1;
			q_nxt.cnt = q_r.cnt + 3'h1;
		end
		// cancellation of pending buffers not on the bus, or of a long fd retry in its id phase
		for (int i = 0; i < `CTXB_NBUF; i++)
		begin
			if (cr[i] && q_r.pend[i])
			begin
				if (!(q_r.st == ctxb_pkg::CTXB_SEND && !q_r.busy_fifo
					&& q_r.bidx == 2'(i)))
				begin
					q_nxt.pend[i] = 1'b0;
					q_nxt.cfin[i] = 1'b1;
				end
				else if (q_r.retry[i] && q_r.lfd[i] && tx_id_phase_i)
				begin
					// retry in its first id bits: false report, frame
					// still runs; long fd frames only
					q_nxt.pend[i] = 1'b0;
					q_nxt.cfin[i] = 1'b1;
				end
			end
		end
		unique case (q_r.st)
			ctxb_pkg::CTXB_IDLE:
			begin
				// fifo first when non empty keeps its queue order
				if (q_r.cnt != 3'd0)
				begin
					q_nxt.txd = q_r.fq[q_r.rp];
					q_nxt.busy_fifo = 1'b1;
					q_nxt.vld = 1'b1;
					q_nxt.st = ctxb_pkg::CTXB_SEND;
				end
				else if (pick_any)
				begin
					q_nxt.bidx = pick_idx;
					q_nxt.txd = q_r.pay[pick_idx];
					q_nxt.busy_fifo = 1'b0;
					q_nxt.vld = 1'b1;
					q_nxt.st = ctxb_pkg::CTXB_SEND;
				end
			end
			ctxb_pkg::CTXB_SEND:
			begin
				if (tx_start_i)
				begin
					q_nxt.vld = 1'b0;
				end
				// frame runs to its end regardless of cancel
				if (tx_done_i)
				begin
					q_nxt.st = ctxb_pkg::CTXB_IDLE;
					q_nxt.vld = 1'b0;
					if (q_r.busy_fifo)
					begin
						if (tx_ok_i || q_r.disable_auto_retransmit)
						begin
							q_nxt.rp = q_r.rp + 2'h1;
							q_nxt.cnt = q_nxt.cnt - 3'h1;
						end
					end
					else if (tx_ok_i)
					begin
						q_nxt.pend[q_r.bidx] = 1'b0;
						q_nxt.retry[q_r.bidx] = 1'b0;
						// cancel report may already stand: it stays set beside occurred
						q_nxt.occ[q_r.bidx] = 1'b1;
					end
					else if (q_r.disable_auto_retransmit)
					begin
						q_nxt.pend[q_r.bidx] = 1'b0;
					end
					else if (q_nxt.pend[q_r.bidx])
					begin
						q_nxt.retry[q_r.bidx] = 1'b1;
					end
				end
			end
			default:
			begin
				q_nxt.st = ctxb_pkg::CTXB_IDLE;
			end
		endcase
		// a dropped or cancelled buffer keeps no retry mark
		q_nxt.retry = q_nxt.retry & q_nxt.pend;
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			q_r <= '0;
		end
		else if (ce_i)
		begin
			q_r <= q_nxt;
		end
	end

	// outputs straight from the state flops
	assign dat_o = q_r.rd;
	assign ack_o = q_r.ack;
	assign fifo_full_o = q_r.cnt[2];
	assign tx_valid_o = q_r.vld;
	assign tx_data_o = q_r.txd;
	assign tx_from_fifo_o = q_r.busy_fifo;
	assign tx_idx_o = q_r.bidx;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	property p_occ_on_ok;
		@(posedge clk_i) disable iff (rst_i)
		ce_i && q_r.st == ctxb_pkg::CTXB_SEND && tx_done_i && tx_ok_i
			&& !q_r.busy_fifo |=> q_r.occ[$past(q_r.bidx)];
	endproperty
	a_occ_on_ok: assert property (p_occ_on_ok)
		else $error("occurred bit not set after good frame");

	property p_cancel_idle;
		@(posedge clk_i) disable iff (rst_i)
		ce_i && cancel_now[0] && q_r.pend[0]
			&& !(q_r.st == ctxb_pkg::CTXB_SEND && !q_r.busy_fifo
			&& q_r.bidx == 2'h0) |=> q_r.cfin[0] && !q_r.pend[0];
	endproperty
	a_cancel_idle: assert property (p_cancel_idle)
		else $error("cancel of idle buffer not reported");

	property p_lowest;
		@(posedge clk_i) disable iff (rst_i)
		ce_i && q_r.st == ctxb_pkg::CTXB_IDLE && q_r.cnt == 3'd0
			&& q_r.pend[0] && !cancel_now[0]
			|=> q_r.bidx == 2'h0 && q_r.vld;
	endproperty
	a_lowest: assert property (p_lowest)
		else $error("lowest pending buffer not chosen");

	property p_hold_data;
		@(posedge clk_i) disable iff (rst_i)
		q_r.st == ctxb_pkg::CTXB_SEND && !tx_done_i
			|=> $stable(q_r.txd);
	endproperty
	a_hold_data: assert property (p_hold_data)
		else $error("frame data changed during send");

	property p_retry;
		@(posedge clk_i) disable iff (rst_i)
		ce_i && q_r.st == ctxb_pkg::CTXB_SEND && tx_done_i && !tx_ok_i
			&& !q_r.disable_auto_retransmit && !q_r.busy_fifo && q_r.pend[q_r.bidx] && !wr
			|=> q_r.pend[$past(q_r.bidx)];
	endproperty
	a_retry: assert property (p_retry)
		else $error("failed buffer dropped with retransmit on");

	// a frame that is not long fd never gives a cancel report on the bus
	property p_classic_cancel;
		@(posedge clk_i) disable iff (rst_i)
		ce_i && q_r.st == ctxb_pkg::CTXB_SEND && !q_r.busy_fifo && !tx_done_i
			&& cancel_now[q_r.bidx] && q_r.pend[q_r.bidx]
			&& !q_r.lfd[q_r.bidx] |=> q_r.pend[$past(q_r.bidx)];
	endproperty
	a_classic_cancel: assert property (p_classic_cancel)
		else $error("cancel of frame on the bus was reported");
endmodule : ctxb_top

// >>> sim/ctxb_ctrl_model.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// protocol controller stand-in
// ---------------------------------------------------------------
module ctxb_ctrl_model
(
	// clock, reset, knobs
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic fail_i,
	input wire logic slow_i,
	// offer from the block
	input wire logic tx_valid_i,
	// progress back to the block
	output logic tx_start_o,
	output logic tx_id_phase_o,
	output logic tx_done_o,
	output logic tx_ok_o
);
	logic busy_r;
	logic [5:0] cnt_r;
	// slow start leaves room to cancel a buffer while it is offered
	always_ff @(posedge clk_i)
	begin
		tx_start_o <= 1'b0;
		tx_done_o <= 1'b0;
		tx_ok_o <= ~tx_ok_o; // no meaning outside done
		if (rst_i)
		begin
			busy_r <= 1'b0;
			cnt_r <= 6'h00;
			tx_id_phase_o <= 1'b0;
			tx_ok_o <= 1'b0;
		end
		else if (!busy_r)
		begin
			cnt_r <= tx_valid_i ? cnt_r + 6'h01 : 6'h00;
			if (tx_valid_i && cnt_r == (slow_i ? 6'h14 : 6'h01))
			begin
				tx_start_o <= 1'b1;
				busy_r <= 1'b1;
				cnt_r <= 6'h00;
			end
		end
		else
		begin
			cnt_r <= cnt_r + 6'h01;
			tx_id_phase_o <= cnt_r < 6'h04;
			if (cnt_r == 6'h0c)
			begin
				tx_done_o <= 1'b1;
				tx_ok_o <= ~fail_i;
				busy_r <= 1'b0;
			end
		end
	end
endmodule : ctxb_ctrl_model

// >>> sim/testbench.sv
`timescale 1ns/10ps
`include "ctxb_cfg.svh"
module testbench;
	logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, push, fail, slow;
	logic vld, start, idp, done, ok, ff, full;
	logic [1:0] idx;
	logic [2:0] src_q[$];
	logic [7:0] adr_i;
	logic [31:0] dat_i, dat_o, txd, fdata, q;
	logic [31:0] log_q[$];
	int num_errors = 0;
	int check_count = 0;
	initial
	begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	ctxb_top ctxb_top_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
		.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.fifo_push_i(push), .fifo_data_i(fdata), .fifo_len_i(7'h40),
		.fifo_fd_i(1'b1), .fifo_full_o(full), .tx_valid_o(vld),
		.tx_data_o(txd), .tx_from_fifo_o(ff), .tx_idx_o(idx),
		.tx_start_i(start), .tx_id_phase_i(idp), .tx_done_i(done),
		.tx_ok_i(ok));
	ctxb_ctrl_model ctxb_ctrl_model_i (.clk_i(clk_i), .rst_i(rst_i),
		.fail_i(fail), .slow_i(slow), .tx_valid_i(vld),
		.tx_start_o(start), .tx_id_phase_o(idp), .tx_done_o(done),
		.tx_ok_o(ok));
	// payload of every good frame, as offered at its end
	always @(posedge clk_i)
	begin
		if (done === 1'b1 && ok === 1'b1)
		begin
			log_q.push_back(txd);
			src_q.push_back({ff, idx});
		end
	end
	task automatic stop_test;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: %h expected %h", $time, got, exp);
		end
	endtask : chk
	// request stands until ack is sampled high at a rising edge
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		logic got;
		n = 0;
		got = 1'b0;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		do
		begin
			@(posedge clk_i);
			n++;
			got = ack_o === 1'b1;
		end
		while (!got && n < 20);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
		if (!got)
		begin
			num_errors++;
			stop_test();
		end
	endtask : wb
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(q, e);
	endtask : rd
	// -1 done, -2 start, else that many logged frames
	task automatic wev(input int s);
		int n;
		logic hit;
		n = 0;
		do
		begin
			@(negedge clk_i);
			n++;
			hit = s == -1 ? done === 1'b1 : s == -2 ? start === 1'b1 :
				log_q.size() >= s;
		end
		while (!hit && n < 500);
		@(posedge clk_i);
		if (!hit)
		begin
			num_errors++;
			stop_test();
		end
	endtask : wev
	initial
	begin
		{cyc_i, stb_i, we_i, push, fail, slow} = 6'h00;
		adr_i = 8'h00;
		dat_i = 32'h0;
		fdata = 32'h0;
		rst_i = 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		for (int a = 8; a <= 28; a += 4) rd(8'(a), 32'h0);
		// distinct payload per buffer, raised by one write
		for (int i = 0; i < 4; i++) wb(1'b1, 8'(32 + 4 * i), 32'ha0 + i);
		wb(1'b1, `CTXB_ADDR_ADD_REQ, 32'hf);
		wev(4);
		for (int i = 0; i < 4; i++) chk(log_q[i], 32'ha0 + i);
		for (int i = 0; i < 4; i++) chk(32'(src_q[i]), 32'(i));
		rd(`CTXB_ADDR_OCCURRED, 32'hf);
		rd(`CTXB_ADDR_PENDING, 32'h0);
		// fifo ahead of a pending buffer, in queue order; fifth push refused
		wb(1'b1, 8'h24, 32'hc1);
		for (int i = 0; i < 5; i++)
		begin
			push <= 1'b1;
			fdata <= 32'hb0 + i;
			@(posedge clk_i);
		end
		push <= 1'b0;
		chk(32'(full), 32'h1);
		wb(1'b1, `CTXB_ADDR_ADD_REQ, 32'h2);
		wev(9);
		for (int i = 4; i < 8; i++)
		begin
			chk(log_q[i], 32'hac + i);
			chk(32'(src_q[i][2]), 32'h1);
		end
		chk(log_q[8], 32'hc1);
		chk(32'(src_q[8]), 32'h1);
		// buffer cancelled while a fifo frame holds the bus: never sent
		slow <= 1'b1;
		push <= 1'b1;
		fdata <= 32'hd0;
		@(posedge clk_i);
		push <= 1'b0;
		wb(1'b1, `CTXB_ADDR_ADD_REQ, 32'h1);
		wb(1'b1, `CTXB_ADDR_CANCEL_REQ, 32'h1);
		wev(10);
		chk(log_q[9], 32'hd0);
		chk(32'(src_q[9][2]), 32'h1);
		rd(`CTXB_ADDR_CANCEL_FIN, 32'h1);
		rd(`CTXB_ADDR_PENDING, 32'h0);
		rd(`CTXB_ADDR_OCCURRED, 32'he);
		// classic frame already offered: cancel held off, frame sent
		wb(1'b1, `CTXB_ADDR_ADD_REQ, 32'h4);
		wb(1'b1, `CTXB_ADDR_CANCEL_REQ, 32'h4);
		wev(11);
		chk(log_q[10], 32'ha2);
		chk(32'(src_q[10]), 32'h2);
		slow <= 1'b0;
		rd(`CTXB_ADDR_CANCEL_FIN, 32'h1);
		rd(`CTXB_ADDR_OCCURRED, 32'he);
		// long fd retry cancelled in its id phase runs on regardless
		wb(1'b1, `CTXB_ADDR_BUF_FMT, 32'h8);
		rd(`CTXB_ADDR_BUF_FMT, 32'h8);
		fail <= 1'b1;
		wb(1'b1, 8'h2c, 32'he3);
		wb(1'b1, `CTXB_ADDR_ADD_REQ, 32'h8);
		wev(-1);
		fail <= 1'b0;
		wev(-2);
		wb(1'b1, `CTXB_ADDR_CANCEL_REQ, 32'h8);
		wb(1'b1, 8'h2c, 32'hf3);
		rd(`CTXB_ADDR_PENDING, 32'h0);
		rd(`CTXB_ADDR_CANCEL_FIN, 32'h9);
		wev(12);
		chk(log_q[11], 32'he3);
		rd(`CTXB_ADDR_OCCURRED, 32'he);
		// retransmit off: failed buffer stays unsent
		wb(1'b1, `CTXB_ADDR_CORE_CTRL, 32'h1);
		rd(`CTXB_ADDR_CORE_CTRL, 32'h1);
		fail <= 1'b1;
		wb(1'b1, `CTXB_ADDR_ADD_REQ, 32'h1);
		wev(-1);
		fail <= 1'b0;
		repeat (40) @(posedge clk_i);
		chk(32'(log_q.size()), 32'd12);
		rd(`CTXB_ADDR_OCCURRED, 32'he);
		rd(`CTXB_ADDR_PENDING, 32'h0);
		rd(`CTXB_ADDR_CANCEL_FIN, 32'h8);
		stop_test();
	end
endmodule : testbench
